// File: table_ops_pkg.sv
// Purpose: Shared constants and types for the table and test execution unit
// Assumes: One instruction cycle is four clocks, one per quarter phase
// Notes: Opcodes are matched as value under mask
package table_ops_pkg;
  localparam int PTR_W = 21;
  localparam int FADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int HOLD_N = 8;
  localparam int HOLD_IDX_W = 3;
  localparam logic [PTR_W-1:0] PTR_ONE = 21'h000001;
  localparam logic [PTR_W-1:0] PTR_RESET = 21'h000000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] HOLD_RESET = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] OP_TBL_MASK = 16'hfffc;
  localparam logic [15:0] OP_PROGRAM_TABLE_READ = 16'h0008;
  localparam logic [15:0] OP_PROGRAM_TABLE_WRITE = 16'h000c;
  localparam logic [15:0] OP_TST_MASK = 16'hfe00;
  localparam logic [15:0] OP_TST = 16'h6600;
  localparam logic [15:0] OP_XOR_MASK = 16'hff00;
  localparam logic [15:0] OP_XOR = 16'h0a00;
  localparam int ACC_BIT = 8;
  localparam logic [7:0] INDEXED_MAX = 8'h5f;
  localparam logic [BANK_W-1:0] ACC_LOW_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACC_HIGH_BANK = 4'hf;
  localparam int CYCLE_CLKS = 4;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } phase_t;

  typedef enum logic [1:0] {
    PTR_KEEP = 2'b00,
    PTR_POST_INC = 2'b01,
    PTR_POST_DEC = 2'b10,
    PTR_PRE_INC = 2'b11
  } ptr_mode_t;

  typedef enum logic [1:0] {
    S_EXEC = 2'b00,
    S_TBL2 = 2'b01,
    S_SKIP1 = 2'b10,
    S_SKIP2 = 2'b11
  } state_t;
endpackage

// File: holding_bank.sv
// Purpose: Eight byte holding registers filled by table writes
// Assumes: Single write port, registered read port for the flash engine
// Notes: Bytes reset to the erased value
`timescale 1ns/1ps
module holding_bank
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [table_ops_pkg::HOLD_IDX_W-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [table_ops_pkg::HOLD_IDX_W-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [table_ops_pkg::HOLD_N];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < table_ops_pkg::HOLD_N; i++)
      begin
        mem[i] <= table_ops_pkg::HOLD_RESET;
      end
    end
    else if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdata <= table_ops_pkg::HOLD_RESET;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end
endmodule

// File: table_access_and_test_ops.sv
// Purpose: Executes table read/write, test-file-skip and xor-literal
// Assumes: File reads answer within the same quarter phase; memory reads by Q4 of cycle two
// Notes: An instruction is taken only at Q1 while instr_ready is high
`timescale 1ns/1ps

// Contract
// (RQ1) Table byte pointer is 21 bits, one byte address each, 2 Mbyte.
// (RQ2) Pointer bit 0 picks low byte (0) or high byte (1) of a word.
// (RQ3) Table read opcode 10nn: keep, post-inc, post-dec, pre-inc pointer.
// (RQ4) Table read fills the latch; two cycles, memory read cycle two, Q4.
// (RQ5) Table write opcode 11nn, same modes, pre-increment before storing.
// (RQ6) Table write stores latch into holding register picked by ptr[2:0].
// (RQ7) Test-skip opcode 0110 011a reads a file register, compares to zero.
// (RQ8) If zero, fetched next instruction is discarded; a no-op cycle runs.
// (RQ9) Skipping a two-word instruction costs three cycles in total.
// (RQ10) Access bit 0 uses the access bank, 1 uses the bank select reg.
// (RQ11) Access bit 0, extended set on, f up to 95: indexed offset mode.
// (RQ12) Xor-literal opcode 0000 1010 xors W with literal, result into W.
// (RQ13) Xor-literal updates only negative and zero flags.
module table_access_and_test_ops
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  output logic [1:0] q_phase,
  input wire logic next_two_word,
  output logic skip_flush,
  input wire logic ext_set_enable,
  input wire logic [table_ops_pkg::BANK_W-1:0] bank_select_reg,
  input wire logic [table_ops_pkg::FADDR_W-1:0] index_base,
  output logic [table_ops_pkg::FADDR_W-1:0] file_addr,
  output logic file_rd,
  input wire logic [7:0] file_rdata,
  output logic [table_ops_pkg::PTR_W-1:0] table_byte_pointer,
  output logic byte_high_sel,
  output logic pm_rd,
  input wire logic [7:0] pm_rdata,
  output logic [7:0] table_data_latch,
  input wire logic ptr_load,
  input wire logic [table_ops_pkg::PTR_W-1:0] ptr_wdata,
  input wire logic latch_load,
  input wire logic [7:0] latch_wdata,
  input wire logic wreg_load,
  input wire logic [7:0] wreg_wdata,
  output logic [7:0] wreg,
  output logic flag_n,
  output logic flag_z,
  output logic nz_update,
  input wire logic [table_ops_pkg::HOLD_IDX_W-1:0] hold_raddr,
  output logic [7:0] hold_rdata
);
  table_ops_pkg::phase_t q;
  table_ops_pkg::state_t state;
  logic [15:0] ir;
  logic is_rd;
  logic is_wt;
  logic is_tst;
  logic is_xor;
  logic take;
  logic fin;
  logic zero_hit;
  logic skip_two;
  logic hold_we;
  logic [7:0] lit;
  logic [7:0] xres;
  logic [table_ops_pkg::FADDR_W-1:0] next_faddr;
  table_ops_pkg::ptr_mode_t mode;

  assign q_phase = q;
  assign instr_ready = (state == table_ops_pkg::S_EXEC) &&
                       (q == table_ops_pkg::Q1);
  assign take = instr_ready && instr_valid;
  assign is_rd = (ir & table_ops_pkg::OP_TBL_MASK) == table_ops_pkg::OP_PROGRAM_TABLE_READ; // RQ3
  assign is_wt = (ir & table_ops_pkg::OP_TBL_MASK) == table_ops_pkg::OP_PROGRAM_TABLE_WRITE; // RQ5
  assign is_tst = (ir & table_ops_pkg::OP_TST_MASK) == table_ops_pkg::OP_TST; // RQ7
  assign is_xor = (ir & table_ops_pkg::OP_XOR_MASK) == table_ops_pkg::OP_XOR; // RQ12
  assign mode = table_ops_pkg::ptr_mode_t'(ir[1:0]);
  assign lit = ir[7:0];
  assign xres = wreg ^ lit;
  assign fin = (state == table_ops_pkg::S_TBL2) && (q == table_ops_pkg::Q4);
  assign byte_high_sel = table_byte_pointer[0]; // RQ2
  assign hold_we = fin && is_wt;

  // File address from the word being taken
  always_comb
  begin
    if (instr_word[table_ops_pkg::ACC_BIT])
    begin
      next_faddr = {bank_select_reg, instr_word[7:0]}; // RQ10
    end
    else if (ext_set_enable &&
             instr_word[7:0] <= table_ops_pkg::INDEXED_MAX)
    begin
      next_faddr = index_base + {4'h0, instr_word[7:0]}; // RQ11
    end
    else if (instr_word[7:0] <= table_ops_pkg::INDEXED_MAX)
    begin
      next_faddr = {table_ops_pkg::ACC_LOW_BANK, instr_word[7:0]}; // RQ10
    end
    else
    begin
      next_faddr = {table_ops_pkg::ACC_HIGH_BANK, instr_word[7:0]}; // RQ10
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q <= table_ops_pkg::Q1;
    end
    else
    begin
      q <= table_ops_pkg::phase_t'(q + 2'h1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ir <= 16'h0000;
      file_addr <= 12'h000;
    end
    else if (take)
    begin
      ir <= instr_word;
      file_addr <= next_faddr;
    end
    // Table ops keep their word until the second cycle ends
    else if (fin || (state == table_ops_pkg::S_EXEC &&
                     q == table_ops_pkg::Q4 && !is_rd && !is_wt))
    begin
      ir <= 16'h0000;
    end
  end

  // Sequencing of second cycles and skipped slots
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= table_ops_pkg::S_EXEC;
    end
    else if (q == table_ops_pkg::Q4)
    begin
      unique case (state)
        table_ops_pkg::S_EXEC:
        begin
          if (is_rd || is_wt)
          begin
            state <= table_ops_pkg::S_TBL2; // RQ4
          end
          else if (is_tst && zero_hit)
          begin
            state <= table_ops_pkg::S_SKIP1; // RQ8
          end
        end
        table_ops_pkg::S_TBL2:
        begin
          state <= table_ops_pkg::S_EXEC;
        end
        table_ops_pkg::S_SKIP1:
        begin
          state <= skip_two ? table_ops_pkg::S_SKIP2 :
                   table_ops_pkg::S_EXEC; // RQ9
        end
        table_ops_pkg::S_SKIP2:
        begin
          state <= table_ops_pkg::S_EXEC;
        end
      endcase
    end
  end

  assign file_rd = (state == table_ops_pkg::S_EXEC) && is_tst &&
                   (q == table_ops_pkg::Q2); // RQ7
  assign skip_flush = (state == table_ops_pkg::S_EXEC) && is_tst &&
                      zero_hit && (q == table_ops_pkg::Q4); // RQ8
  assign pm_rd = (state == table_ops_pkg::S_TBL2) && is_rd &&
                 (q == table_ops_pkg::Q2); // RQ4

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      zero_hit <= 1'b0;
      skip_two <= 1'b0;
    end
    else if (take)
    begin
      zero_hit <= 1'b0;
    end
    else if (file_rd)
    begin
      zero_hit <= file_rdata == table_ops_pkg::BYTE_ZERO; // RQ7
    end
    else if (skip_flush)
    begin
      skip_two <= next_two_word; // RQ9
    end
  end

  // Pointer: 21-bit byte address with the four update modes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      table_byte_pointer <= table_ops_pkg::PTR_RESET; // RQ1
    end
    else if (ptr_load)
    begin
      table_byte_pointer <= ptr_wdata;
    end
    else if ((is_rd || is_wt) && state == table_ops_pkg::S_EXEC &&
             q == table_ops_pkg::Q4 && mode == table_ops_pkg::PTR_PRE_INC)
    begin
      table_byte_pointer <= table_byte_pointer +
                            table_ops_pkg::PTR_ONE; // RQ3 RQ5
    end
    else if (fin && mode == table_ops_pkg::PTR_POST_INC)
    begin
      table_byte_pointer <= table_byte_pointer +
                            table_ops_pkg::PTR_ONE; // RQ3 RQ5
    end
    else if (fin && mode == table_ops_pkg::PTR_POST_DEC)
    begin
      table_byte_pointer <= table_byte_pointer -
                            table_ops_pkg::PTR_ONE; // RQ3 RQ5
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      table_data_latch <= table_ops_pkg::BYTE_RESET;
    end
    else if (fin && is_rd)
    begin
      table_data_latch <= pm_rdata; // RQ4
    end
    else if (latch_load)
    begin
      table_data_latch <= latch_wdata;
    end
  end

  holding_bank u_hold
  (
    .clk(clk),
    .rst_n(rst_n),
    .we(hold_we),
    .waddr(table_byte_pointer[table_ops_pkg::HOLD_IDX_W-1:0]), // RQ6
    .wdata(table_data_latch),
    .raddr(hold_raddr),
    .rdata(hold_rdata)
  );

  assign nz_update = (state == table_ops_pkg::S_EXEC) && is_xor &&
                     (q == table_ops_pkg::Q4); // RQ13

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wreg <= table_ops_pkg::BYTE_RESET;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
    end
    else if (nz_update)
    begin
      wreg <= xres; // RQ12
      flag_n <= xres[7]; // RQ13
      flag_z <= xres == table_ops_pkg::BYTE_ZERO; // RQ13
    end
    else if (wreg_load)
    begin
      wreg <= wreg_wdata;
    end
  end

  sequence s_take_table;
    take && (instr_word[15:3] == 13'h0001);
  endsequence
  sequence s_two_cycles_busy;
    !instr_ready [*7] ##1 instr_ready;
  endsequence

  property p_ptr_width;
    @(posedge clk) disable iff (!rst_n)
    ptr_load |=> table_byte_pointer == $past(ptr_wdata);
  endproperty
  a_ptr_width: assert property (p_ptr_width) // RQ1
    else $error("pointer load lost bits");

  property p_table_two_cycles;
    @(posedge clk) disable iff (!rst_n)
    s_take_table |=> s_two_cycles_busy;
  endproperty
  a_table_two_cycles: assert property (p_table_two_cycles) // RQ4
    else $error("table op not two instruction cycles");

  property p_read_latch;
    @(posedge clk) disable iff (!rst_n)
    pm_rd |-> ##2 (fin ##1 table_data_latch == $past(pm_rdata));
  endproperty
  a_read_latch: assert property (p_read_latch) // RQ4
    else $error("latch not loaded at Q4 of second cycle");

  property p_post_inc;
    @(posedge clk) disable iff (!rst_n)
    fin && mode == table_ops_pkg::PTR_POST_INC && !ptr_load
    |=> table_byte_pointer == $past(table_byte_pointer) + 21'h000001;
  endproperty
  a_post_inc: assert property (p_post_inc) // RQ3
    else $error("post increment wrong");

  property p_hold_index;
    @(posedge clk) disable iff (!rst_n)
    hold_we |=> ##1 ($past(hold_raddr) != $past(table_byte_pointer[2:0], 2)
                     || hold_rdata == $past(table_data_latch, 2));
  endproperty
  a_hold_index: assert property (p_hold_index) // RQ6
    else $error("holding register index wrong");

  property p_skip_one;
    @(posedge clk) disable iff (!rst_n)
    skip_flush && !next_two_word |=> !instr_ready [*4] ##1 instr_ready;
  endproperty
  a_skip_one: assert property (p_skip_one) // RQ8
    else $error("single skip not one no-op cycle");

  property p_skip_two;
    @(posedge clk) disable iff (!rst_n)
    skip_flush && next_two_word |=> !instr_ready [*8] ##1 instr_ready;
  endproperty
  a_skip_two: assert property (p_skip_two) // RQ9
    else $error("two-word skip not two no-op cycles");

  property p_bank_sel;
    @(posedge clk) disable iff (!rst_n)
    take && instr_word[8] |=> file_addr[11:8] == $past(bank_select_reg);
  endproperty
  a_bank_sel: assert property (p_bank_sel) // RQ10
    else $error("bank select not used");

  property p_xor;
    @(posedge clk) disable iff (!rst_n)
    nz_update |=> wreg == ($past(wreg) ^ $past(lit)) &&
                  flag_z == (wreg == 8'h00) && flag_n == wreg[7];
  endproperty
  a_xor: assert property (p_xor) // RQ12 RQ13
    else $error("xor result or flags wrong");
endmodule

// File: pm_file_model.sv
// Purpose: Far-side model of program memory and file registers
// Assumes: Read data must stay valid from the read pulse to the latch edge
// Notes: Undriven data toggles every clock so stale bytes cannot pass
`timescale 1ns/1ps
module pm_file_model
(
  input wire logic clk,
  input wire logic pm_rd,
  input wire logic [20:0] table_byte_pointer,
  output logic [7:0] pm_rdata,
  input wire logic file_rd,
  input wire logic [11:0] file_addr,
  output logic [7:0] file_rdata
);
  logic [20:0] addr = 21'h000000;
  logic [1:0] hold = 2'h0;
  logic [7:0] junk = 8'h5a;
  always @(posedge clk)
  begin
    junk <= ~junk + 8'h01;
    hold <= pm_rd ? 2'h3 : (hold != 2'h0 ? hold - 2'h1 : hold);
    if (pm_rd)
      addr <= table_byte_pointer;
  end
  // Byte held through the fourth phase of the second cycle
  assign pm_rdata = hold != 2'h0 ?
    addr[7:0] ^ addr[15:8] ^ {3'h0, addr[20:16]} : junk;
  // Odd file addresses hold zero
  assign file_rdata = !file_rd ? junk :
    (file_addr[0] ? 8'h00 : {file_addr[7:1], 1'b1});
endmodule

// File: testbench.sv
// Purpose: Self-checking bench for the table and test execution unit
// Assumes: One instruction cycle is four clocks
// Notes: Random operations from a fixed-seed shift register
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic next_two_word = 1'b0;
  logic ext_set_enable = 1'b0;
  logic [3:0] bank_select_reg = 4'h0;
  logic [11:0] index_base = 12'h000;
  logic ptr_load = 1'b0;
  logic [20:0] ptr_wdata = 21'h000000;
  logic latch_load = 1'b0;
  logic [7:0] latch_wdata = 8'h00;
  logic wreg_load = 1'b0;
  logic [7:0] wreg_wdata = 8'h00;
  logic [2:0] hold_raddr = 3'h0;
  logic instr_ready, skip_flush, file_rd, byte_high_sel, pm_rd;
  logic flag_n, flag_z, nz_update;
  logic [1:0] q_phase;
  logic [11:0] file_addr, fa;
  logic [7:0] file_rdata, pm_rdata, table_data_latch, wreg, hold_rdata;
  logic [20:0] table_byte_pointer, ptr;
  logic [7:0] lat, w;
  logic [7:0] hold [8];
  logic [31:0] rnd;
  int num_errors = 0;
  int n_checks = 0;
  int n, fl, fr, pr, nz;

  table_access_and_test_ops dut (.clk, .rst_n, .instr_valid, .instr_word,
    .instr_ready, .q_phase, .next_two_word, .skip_flush, .ext_set_enable,
    .bank_select_reg, .index_base, .file_addr, .file_rd, .file_rdata,
    .table_byte_pointer, .byte_high_sel, .pm_rd, .pm_rdata,
    .table_data_latch, .ptr_load, .ptr_wdata, .latch_load, .latch_wdata,
    .wreg_load, .wreg_wdata, .wreg, .flag_n, .flag_z, .nz_update,
    .hold_raddr, .hold_rdata);
  pm_file_model mem (.clk, .pm_rd, .table_byte_pointer, .pm_rdata,
    .file_rd, .file_addr, .file_rdata);

  initial
    forever #5 clk = ~clk;

  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  function automatic logic [7:0] mem_b(logic [20:0] a);
    return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
  endfunction

  function automatic logic [11:0] efa(logic a, logic [7:0] f);
    if (a)
      return {bank_select_reg, f};
    if (ext_set_enable && f <= 8'h5f)
      return index_base + {4'h0, f};
    return {(f < 8'h60) ? 4'h0 : 4'hf, f};
  endfunction

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok)
    begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic rdh(input logic [2:0] i);
    @(posedge clk);
    hold_raddr <= i;
    @(posedge clk);
    #1;
    chk(hold_rdata === hold[i], "holding byte");
  endtask

  task automatic load(input logic [20:0] p, input logic [7:0] l, v);
    @(posedge clk);
    {ptr_load, latch_load, wreg_load} <= 3'b111;
    ptr_wdata <= p;
    latch_wdata <= l;
    wreg_wdata <= v;
    @(posedge clk);
    {ptr_load, latch_load, wreg_load} <= 3'b000;
    ptr = p;
    lat = l;
    w = v;
  endtask

  // Offers a word, then logs the clock of each pulse until free again
  task automatic run(input logic [15:0] iw);
    rnd = lfsr(rnd);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= iw;
    next_two_word <= rnd[0];
    ext_set_enable <= rnd[1];
    bank_select_reg <= rnd[5:2];
    index_base <= rnd[17:6];
    {fl, fr, pr, nz} = '0;
    @(negedge clk);
    for (int i = 0; i < 20 && instr_ready !== 1'b1; i++)
      @(negedge clk);
    @(posedge clk);
    instr_valid <= 1'b0;
    // The n-th falling edge shows what the design samples at edge n
    for (n = 1; n < 20; n++)
    begin
      @(negedge clk);
      if (skip_flush === 1'b1)
        fl = n;
      if (pm_rd === 1'b1)
        pr = n;
      if (nz_update === 1'b1)
        nz = n;
      if (file_rd === 1'b1)
      begin
        fr = n;
        fa = file_addr;
      end
      if (instr_ready === 1'b1)
        break;
    end
  endtask

  task automatic op(input logic [1:0] k, m, input logic [7:0] f,
    input logic a);
    logic [11:0] e;
    logic [2:0] hx;
    if (k[1] == 1'b0)
    begin
      run({12'h000, 1'b1, k[0], m});
      if (m == 2'h3)
        ptr++;
      hx = ptr[2:0];
      if (k[0])
        hold[hx] = lat;
      else
        lat = mem_b(ptr);
      if (m == 2'h1)
        ptr++;
      if (m == 2'h2)
        ptr--;
      chk(n == 8 && table_byte_pointer === ptr, "table pointer");
      chk(byte_high_sel === ptr[0], "byte select");
      if (k[0])
        rdh(hx);
      else
        chk(pr == 5 && table_data_latch === lat, "table read");
    end
    else if (k[0] == 1'b0)
    begin
      run({7'b0110011, a, f});
      e = efa(a, f);
      chk(fr == 1 && fa === e, "file address");
      chk(n == (e[0] ? (next_two_word ? 12 : 8) : 4), "skip length");
      chk(fl == (e[0] ? 3 : 0), "skip flush");
    end
    else
    begin
      run({8'h0a, f});
      w = w ^ f;
      chk(n == 4 && nz == 3 && wreg === w, "xor result");
      chk(flag_n === w[7] && flag_z === (w == 8'h00), "xor flags");
    end
  endtask

  initial
  begin
    #100000;
    num_errors++;
    test_done;
  end

  initial
  begin
    rnd = 32'hc4487274;
    {ptr, lat, w} = '0;
    foreach (hold[i])
      hold[i] = table_ops_pkg::HOLD_RESET;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({table_byte_pointer, table_data_latch, wreg, flag_n, flag_z} === '0
      && instr_ready === 1'b1 && q_phase === 2'h0, "reset state");
    for (int i = 0; i < 8; i++)
      rdh(i[2:0]);
    load(21'h1fffff, 8'h3c, 8'haf);
    op(2'h0, 2'h1, 8'h00, 1'b0);
    op(2'h1, 2'h3, 8'h00, 1'b0);
    op(2'h0, 2'h2, 8'h00, 1'b0);
    op(2'h1, 2'h2, 8'h00, 1'b0);
    op(2'h3, 2'h0, 8'haf, 1'b0);
    op(2'h3, 2'h0, 8'h30, 1'b0);
    op(2'h2, 2'h0, 8'h5f, 1'b0);
    op(2'h2, 2'h0, 8'h60, 1'b0);
    repeat (80)
    begin
      rnd = lfsr(rnd);
      if (rnd[3:2] == 2'h0)
        load(rnd[31:11], rnd[15:8], rnd[23:16]);
      op(rnd[1:0], rnd[5:4], rnd[13:6], rnd[7]);
    end
    for (int i = 0; i < 8; i++)
      rdh(i[2:0]);
    test_done;
  end
endmodule
